// [rivm_pkg.sv]
package rivm_pkg;

	// Slot count, request count and address widths of the vector map.
	localparam int NUM_SLOTS = 20;
	localparam int NUM_IRQ = 19;
	localparam int SLOT_W = 5;
	localparam int ADDR_W = 16;

	// Index of the reset slot inside the request vector (slot number minus one).
	localparam logic [SLOT_W-1:0] RESET_INDEX = 5'h00;
	localparam logic [ADDR_W-1:0] RESET_VECTOR_ADDR = 16'h0000;

	// Shift applied to the slot index to form the word address of a vector.
	localparam int STEP_SHIFT_NARROW = 0;
	localparam int STEP_SHIFT_WIDE = 1;

	// Address of the last vector in each variant.
	localparam logic [ADDR_W-1:0] LAST_ADDR_NARROW = 16'h0013;
	localparam logic [ADDR_W-1:0] LAST_ADDR_WIDE = 16'h0026;

	// Reset values of the offer registers.
	localparam logic RESET_PEND_INIT = 1'b1;
	localparam logic [NUM_SLOTS-1:0] TAKEN_INIT = 20'h00000;

	typedef enum logic {
		RIVM_IDLE,
		RIVM_OFFER
	} rivm_state_t;

	// Slot index to program word address; wide selects two-word spacing.
	function automatic logic [ADDR_W-1:0] rivm_vector_addr(input logic [SLOT_W-1:0] idx,
		input logic wide);
		logic [ADDR_W-1:0] base;
		base = {{(ADDR_W-SLOT_W){1'b0}}, idx};
		if (wide) begin
			rivm_vector_addr = base << STEP_SHIFT_WIDE;
		end else begin
			rivm_vector_addr = base << STEP_SHIFT_NARROW;
		end
	endfunction

endpackage

// [rivm_prio.sv]
`timescale 1ns/1ps
module rivm_prio #(
	parameter int N = 20,
	parameter int IDX_W = 5
) (
	input wire logic [N-1:0] req,
	output logic found,
	output logic [IDX_W-1:0] index
);

	// The loop runs downward so the lowest set bit is the one that remains.
	always_comb begin
		found = 1'b0;
		index = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i]) begin
				found = 1'b1;
				index = IDX_W'(i);
			end
		end
	end

endmodule

// [rivm_top.sv]
`timescale 1ns/1ps
// Function
// - Slot 1 at address 0x0000 serves every reset cause.
// - Slots 2 to 5: external requests zero, one, pin toggle groups zero, one.
// - Slots 6 to 12: watchdog, wide timer four events, narrow timer two events.
// - Slots 13 to 20: LIN done, LIN error, SPI, ADC, EEPROM, comparator, serial pair.
// - Smaller variant: vector address is slot minus one, last at 0x0013.
// - Larger variant: vector address is twice slot minus one, last at 0x0026.
module rivm_top #(
	parameter bit WIDE_VECTORS = 1'b1
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic ext_pin_reset,
	input wire logic power_on_reset,
	input wire logic brown_out_reset,
	input wire logic watchdog_system_reset,
	input wire logic irq_global_enable,
	input wire logic ext_request_zero,
	input wire logic ext_request_one,
	input wire logic pin_toggle_group_zero,
	input wire logic pin_toggle_group_one,
	input wire logic watchdog_timeout_request,
	input wire logic wide_timer_capture,
	input wire logic wide_timer_match_a,
	input wire logic wide_timer_match_b,
	input wire logic wide_timer_wrap,
	input wire logic narrow_timer_match_a,
	input wire logic narrow_timer_wrap,
	input wire logic lin_transfer_done,
	input wire logic lin_error_seen,
	input wire logic spi_transfer_done,
	input wire logic adc_conversion_done,
	input wire logic eeprom_idle,
	input wire logic analog_compare_event,
	input wire logic serial_start_seen,
	input wire logic serial_counter_wrap,
	input wire logic core_take,
	output logic vector_valid,
	output logic vector_is_reset,
	output logic [rivm_pkg::ADDR_W-1:0] vector_addr,
	output logic [rivm_pkg::SLOT_W-1:0] vector_slot,
	output logic [rivm_pkg::NUM_SLOTS-1:0] source_taken
);
	import rivm_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Reset cause capture.

	logic reset_cause;
	logic reset_pend_reg;
	logic reset_pend_next;
	logic take_now;

	// Every cause lands in the same slot, so the causes are merged here.
	assign reset_cause = ext_pin_reset | power_on_reset | brown_out_reset
		| watchdog_system_reset;

	// The pending reset comes up set because leaving the block reset is itself
	// a power-on; a new cause in the cycle of a take keeps the flag set.
	assign reset_pend_next = reset_cause
		| (reset_pend_reg & ~(take_now & vector_is_reset));

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			reset_pend_reg <= RESET_PEND_INIT;
		end else if (clk_en) begin
			reset_pend_reg <= reset_pend_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Request vector, one bit for each slot, slot one at bit zero.

	logic [NUM_IRQ-1:0] irq_raw;
	logic [NUM_IRQ-1:0] irq_gated;
	logic [NUM_SLOTS-1:0] slot_req;

	assign irq_raw[0] = ext_request_zero;
	assign irq_raw[1] = ext_request_one;
	assign irq_raw[2] = pin_toggle_group_zero;
	assign irq_raw[3] = pin_toggle_group_one;
	assign irq_raw[4] = watchdog_timeout_request;
	assign irq_raw[5] = wide_timer_capture;
	assign irq_raw[6] = wide_timer_match_a;
	assign irq_raw[7] = wide_timer_match_b;
	assign irq_raw[8] = wide_timer_wrap;
	assign irq_raw[9] = narrow_timer_match_a;
	assign irq_raw[10] = narrow_timer_wrap;
	assign irq_raw[11] = lin_transfer_done;
	assign irq_raw[12] = lin_error_seen;
	assign irq_raw[13] = spi_transfer_done;
	assign irq_raw[14] = adc_conversion_done;
	assign irq_raw[15] = eeprom_idle;
	assign irq_raw[16] = analog_compare_event;
	assign irq_raw[17] = serial_start_seen;
	assign irq_raw[18] = serial_counter_wrap;

	// The global enable masks peripheral requests only; reset is never masked.
	assign irq_gated = irq_global_enable ? irq_raw : '0;

	// In the cycle after a take the taken source has not yet dropped its flag,
	// so its bit is held off for that one cycle to avoid a second entry.
	assign slot_req = {irq_gated, reset_pend_reg} & ~source_taken;

	////////////////////////////////////////////////////////////////////////////////
	// Selection.

	logic sel_found;
	logic [SLOT_W-1:0] sel_index;
	logic sel_is_reset;
	logic [ADDR_W-1:0] sel_addr;

	rivm_prio #(
		.N(NUM_SLOTS),
		.IDX_W(SLOT_W)
	) u_prio (
		.req(slot_req),
		.found(sel_found),
		.index(sel_index)
	);

	assign sel_is_reset = sel_found && (sel_index == RESET_INDEX);

	// The two memory variants differ only in the spacing of the vectors.
	assign sel_addr = sel_is_reset ? RESET_VECTOR_ADDR
		: rivm_vector_addr(sel_index, WIDE_VECTORS);

	////////////////////////////////////////////////////////////////////////////////
	// Offer to the core.

	rivm_state_t state_reg;
	rivm_state_t state_next;
	logic valid_next;
	logic is_reset_next;
	logic [ADDR_W-1:0] addr_reg;
	logic [ADDR_W-1:0] addr_next;
	logic [SLOT_W-1:0] slot_reg;
	logic [SLOT_W-1:0] slot_next;
	logic [NUM_SLOTS-1:0] taken_next;
	logic valid_reg;
	logic is_reset_reg;
	logic [NUM_SLOTS-1:0] taken_reg;

	// A take is honoured only while a vector is on offer.
	assign take_now = core_take && (state_reg == RIVM_OFFER);

	// The offer is re-evaluated every cycle until it is taken, so a higher
	// source or a reset that arrives meanwhile replaces it, and a request
	// withdrawn by software before the take drops the offer.
	always_comb begin
		state_next = state_reg;
		valid_next = valid_reg;
		is_reset_next = is_reset_reg;
		addr_next = addr_reg;
		slot_next = slot_reg;
		taken_next = TAKEN_INIT;
		unique case (state_reg)
			RIVM_IDLE: begin
				valid_next = sel_found;
				is_reset_next = sel_is_reset;
				addr_next = sel_addr;
				slot_next = sel_index + SLOT_W'(1);
				if (sel_found) begin
					state_next = RIVM_OFFER;
				end
			end
			RIVM_OFFER: begin
				if (take_now) begin
					taken_next[slot_reg - SLOT_W'(1)] = 1'b1;
					valid_next = 1'b0;
					is_reset_next = 1'b0;
					state_next = RIVM_IDLE;
				end else begin
					valid_next = sel_found;
					is_reset_next = sel_is_reset;
					addr_next = sel_addr;
					slot_next = sel_index + SLOT_W'(1);
					if (!sel_found) begin
						state_next = RIVM_IDLE;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_reg <= RIVM_IDLE;
			valid_reg <= 1'b0;
			is_reset_reg <= 1'b0;
			addr_reg <= RESET_VECTOR_ADDR;
			slot_reg <= '0;
			taken_reg <= TAKEN_INIT;
		end else if (clk_en) begin
			state_reg <= state_next;
			valid_reg <= valid_next;
			is_reset_reg <= is_reset_next;
			addr_reg <= addr_next;
			slot_reg <= slot_next;
			taken_reg <= taken_next;
		end
	end

	assign source_taken = taken_reg;
	assign vector_valid = valid_reg;
	assign vector_is_reset = is_reset_reg;
	assign vector_addr = addr_reg;
	assign vector_slot = slot_reg;

endmodule

// [rivm_chk.sv]
`timescale 1ns/1ps
module rivm_chk #(
	parameter bit WIDE_VECTORS = 1'b1
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic irq_global_enable,
	input wire logic core_take,
	input wire logic vector_valid,
	input wire logic vector_is_reset,
	input wire logic [rivm_pkg::ADDR_W-1:0] vector_addr,
	input wire logic [rivm_pkg::SLOT_W-1:0] vector_slot,
	input wire logic [rivm_pkg::NUM_SLOTS-1:0] source_taken
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence s_take; vector_valid && core_take; endsequence
	sequence s_gap; !vector_valid && source_taken != 20'h00000; endsequence
	property p_rst_vec; vector_is_reset |-> vector_slot == 5'h01 && vector_addr == 16'h0000; endproperty
	a_rst_vec: assert property (p_rst_vec) else $error("reset offer misplaced");
	property p_narrow; vector_valid && !WIDE_VECTORS |-> vector_addr == {11'h000, vector_slot - 5'h01}; endproperty
	a_narrow: assert property (p_narrow) else $error("narrow address wrong");
	property p_wide; vector_valid && WIDE_VECTORS |-> vector_addr == {10'h000, vector_slot - 5'h01, 1'b0}; endproperty
	a_wide: assert property (p_wide) else $error("wide address wrong");
	property p_last; vector_valid && vector_slot == 5'h14 |-> vector_addr == (WIDE_VECTORS ? 16'h0026 : 16'h0013); endproperty
	a_last: assert property (p_last) else $error("last vector wrong");
	property p_range; vector_valid |-> vector_slot inside {[5'h01:5'h14]}; endproperty
	a_range: assert property (p_range) else $error("slot out of map");
	property p_taken; s_take |=> source_taken == 20'h00001 << ($past(vector_slot) - 5'h01); endproperty
	a_taken: assert property (p_taken) else $error("wrong source taken");
	property p_gap; s_take |=> s_gap ##1 source_taken == 20'h00000; endproperty
	a_gap: assert property (p_gap) else $error("take sequence wrong");
	property p_gate; vector_valid && !vector_is_reset |-> $past(irq_global_enable); endproperty
	a_gate: assert property (p_gate) else $error("offer while gated");
endmodule
bind rivm_top rivm_chk #(.WIDE_VECTORS(WIDE_VECTORS)) u_chk (.*);

// [rivm_core.sv]
`timescale 1ns/1ps
module rivm_core (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic vector_valid,
	input wire logic [3:0] stall,
	output logic core_take
);
	logic [3:0] wait_reg;
	// The take is held until the edge that sees it, so a stalled core may be overtaken by a preempting offer.
	always @(negedge clk_sys or posedge rst) begin
		if (rst || !vector_valid) begin
			wait_reg <= 4'h0;
			core_take <= 1'b0;
		end else begin
			core_take <= wait_reg >= stall;
			wait_reg <= wait_reg + 4'h1;
		end
	end
endmodule

// [rivm_tb.sv]
`timescale 1ns/1ps
module tb;
	import rivm_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic clk_en = 1'b1;
	logic irq_global_enable = 1'b1;
	logic [3:0] cause = 4'h0;
	logic [18:0] req = 19'h00000;
	logic [3:0] stall = 4'h0;
	logic pend = 1'b1;
	logic [31:0] lfsr = 32'h3FA1;
	logic [15:0] addr_n;
	logic [4:0] exp_slot = 5'h01;
	int err_total = 0;
	int total_checks = 0;
	int cycles = 0;
	wire ext_request_zero, ext_request_one, pin_toggle_group_zero, pin_toggle_group_one;
	wire watchdog_timeout_request, wide_timer_capture, wide_timer_match_a, wide_timer_match_b;
	wire wide_timer_wrap, narrow_timer_match_a, narrow_timer_wrap, lin_transfer_done;
	wire lin_error_seen, spi_transfer_done, adc_conversion_done, eeprom_idle;
	wire analog_compare_event, serial_start_seen, serial_counter_wrap;
	wire ext_pin_reset, power_on_reset, brown_out_reset, watchdog_system_reset;
	wire core_take, vector_valid, vector_is_reset;
	wire [ADDR_W-1:0] vector_addr;
	wire [SLOT_W-1:0] vector_slot;
	wire [NUM_SLOTS-1:0] source_taken;
	assign {serial_counter_wrap, serial_start_seen, analog_compare_event, eeprom_idle,
		adc_conversion_done, spi_transfer_done, lin_error_seen, lin_transfer_done,
		narrow_timer_wrap, narrow_timer_match_a, wide_timer_wrap, wide_timer_match_b,
		wide_timer_match_a, wide_timer_capture, watchdog_timeout_request, pin_toggle_group_one,
		pin_toggle_group_zero, ext_request_one, ext_request_zero} = req;
	assign {watchdog_system_reset, brown_out_reset, power_on_reset, ext_pin_reset} = cause;
	rivm_top dut (.*);
	rivm_top #(.WIDE_VECTORS(1'b0)) dut_n (.vector_valid(), .vector_is_reset(), .vector_slot(),
		.source_taken(), .vector_addr(addr_n), .*);
	rivm_core core (.*);
	always #2.5 clk_sys = ~clk_sys;
	////////////////////////////////////////////////////////////
	task automatic cmp(input string what, input logic [19:0] exp, input logic [19:0] got);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	// The model expects the lowest pending slot, with a pending reset ahead of everything.
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 40000) begin
			err_total++;
			end_of_test();
		end
		if (!rst && vector_valid && core_take) begin
			exp_slot = 5'h01;
			for (int i = 18; i >= 0 && !pend; i--) begin
				if (req[i]) begin
					exp_slot = 5'(i + 2);
				end
			end
			cmp("slot", exp_slot, vector_slot);
			cmp("addr_wide", 16'(exp_slot - 1) << 1, vector_addr);
			cmp("addr_narrow", 16'(exp_slot - 1), addr_n);
			cmp("is_reset", exp_slot == 5'h01, vector_is_reset);
		end
	end
	// Peripherals drop their level once they see their taken pulse.
	always @(negedge clk_sys) begin
		if (source_taken !== 20'h00000) begin
			cmp("taken", 20'h00001 << (exp_slot - 1), source_taken);
			if (exp_slot == 5'h01) begin
				pend = 1'b0;
			end else begin
				req[exp_slot - 2] = 1'b0;
			end
		end
	end
	initial begin
		repeat (12) @(posedge clk_sys);
		@(negedge clk_sys);
		rst = 1'b0;
		for (int b = 0; b < 48; b++) begin
			for (int w = 0; w < 1000 && {req, pend, vector_valid, source_taken} != 0; w++) begin
				@(negedge clk_sys);
			end
			lfsr = lfsr_next(lfsr);
			stall = lfsr[22:19];
			// A cause lands one cycle ahead of the requests so the sticky flag is
			// already set when they are first seen; the wait above has drained every
			// offer, so none made before the cause can still be taken.
			if (b % 4 == 3) begin
				cause = 4'h1 << (b / 4 % 4);
				pend = 1'b1;
				@(negedge clk_sys);
				cause = 4'h0;
			end
			req = (b == 0) ? 19'h7FFFF : lfsr[18:0];
			if (b == 5) begin
				irq_global_enable = 1'b0;
				repeat (8) begin
					@(negedge clk_sys);
					cmp("gated_valid", 1'b0, vector_valid);
				end
				irq_global_enable = 1'b1;
			end
			@(negedge clk_sys);
			cause = 4'h0;
		end
		end_of_test();
	end
endmodule
